// ===== ftbs_pkg.sv
/*
 * shared types and constants for the flow-through burst sram control block.
 * assumes a single rising-edge clock and no software-visible registers.
 */
package ftbs_pkg;
	localparam int ADDR_W_DEF  = 17;
	localparam int LANES_DEF   = 4;
	localparam int LANE_W_DEF  = 9;
	localparam int BURST_W     = 2;
	localparam logic [1:0] BURST_CNT_RST = 2'h0;
	localparam logic       SLEEP_RST     = 1'b1;

	typedef enum logic [1:0] {
		FTBS_IDLE,
		FTBS_READ,
		FTBS_WRITE
	} ftbs_op_t;

	typedef struct packed {
		logic chip_select_low_primary_n;
		logic chip_select_low_secondary_n;
		logic chip_select_high;
		logic burst_advance_load;
		logic read_write_n;
		logic clock_enable_n;
	} ftbs_ctrl_t;
endpackage : ftbs_pkg

// ===== ftbs_skid.sv
/*
 * two-entry buffer with valid and ready on both sides.
 * assumes both sides on sys_clk_i; the drain side may stall freely.
 */
`timescale 1ns/1ps
module ftbs_skid #(
	parameter int W = 8
) (
	input  wire logic         sys_clk_i,
	input  wire logic         reset_n_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	logic [W-1:0] mem_q [2];
	logic         wr_ptr_q;
	logic         rd_ptr_q;
	logic [1:0]   count_q;
	logic         push;
	logic         pop;

	assign in_ready_o  = (count_q != 2'h2);
	assign out_valid_o = (count_q != 2'h0);
	assign out_data_o  = mem_q[rd_ptr_q];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : ftbs_skid

// ===== ftbs_ctrl.sv
/*
 * command decode, burst control and byte-lane array of a flow-through sram.
 * assumes a synchronous controller on sys_clk_i; sleep and output enable async.
 */
// Notes on behaviour
// - a write stores only byte lanes whose active-low write enable is low.
// - lane enable n gates data lane n; narrow build has two lanes.
// - write with all lane enables high is an abort; nothing stored, bus idle.
// - read with output enable high is a dummy read; bus stays idle.
// - extended idle follows deselect or reset; bus idle in both.
// - burst continuation repeats the operation latched at burst start.
// - burst counter advances on every continuation, dummy or aborted too.
// - two-bit counter on low address bits wraps every fourth cycle.
// - output drivers turn off during any write by themselves.
// - clock enable high freezes state, address and burst position.
// - stall during read keeps bus driven; during write keeps it idle.
// - no array write on an ignored clock edge.
// - state changes only on the rising clock edge, except on asynchronous reset.
// - data bus stays high impedance from power-up until a valid read.
// - advance high ignores read/write and advances; low loads new address.
// - burst order low selects linear, high interleaved; held static.
`timescale 1ns/1ps
module ftbs_ctrl #(
	parameter int ADDR_W = ftbs_pkg::ADDR_W_DEF,
	parameter int LANES  = ftbs_pkg::LANES_DEF,
	parameter int LANE_W = ftbs_pkg::LANE_W_DEF
) (
	input  wire logic                    sys_clk_i,
	input  wire logic                    reset_n_i,
	input  wire ftbs_pkg::ftbs_ctrl_t    ctrl_i,
	input  wire logic [ADDR_W-1:0]       addr_i,
	input  wire logic [LANES-1:0]        byte_write_group_n_i,
	input  wire logic                    output_enable_n_i,
	input  wire logic                    sleep_request_i,
	input  wire logic                    burst_order_select_i,
	input  wire logic [LANES*LANE_W-1:0] data_i,
	output logic      [LANES*LANE_W-1:0] data_o,
	output logic      [LANES*LANE_W-1:0] data_oe_o,
	output logic                         low_power_sleep_state_o,
	output logic                         rd_valid_o,
	input  wire logic                    rd_ready_i,
	output logic      [LANES*LANE_W-1:0] rd_data_o
);
	localparam int DW    = LANES * LANE_W;
	localparam int DEPTH = 1 << ADDR_W;

	logic [DW-1:0]           array_q [DEPTH];
	ftbs_pkg::ftbs_op_t      op_q;
	logic [ADDR_W-1:0]       base_addr_q;
	logic [1:0]              burst_cnt_q;
	logic                    drive_q;
	logic [DW-1:0]           dout_q;
	logic [1:0]              sleep_sync_q;
	logic [1:0]              oe_sync_q;
	logic                    sleep;
	logic                    oe_active;
	logic                    run;
	logic                    selected;
	logic                    load;
	logic                    advance;
	logic                    new_read;
	logic                    new_write;
	logic                    cont_burst;
	logic [ADDR_W-1:0]       cur_addr;
	logic [1:0]              next_cnt;
	logic                    do_write;
	logic                    do_read;
	logic [LANES-1:0]        lane_we;
	logic [DW-1:0]           lane_mask;
	logic                    buf_ready;
	logic                    buf_in_valid;

	function automatic logic [1:0] burst_low(
		input logic [1:0] start,
		input logic [1:0] cnt,
		input logic       interleave
	);
		burst_low = interleave ? (start ^ cnt) : (start + cnt);
	endfunction : burst_low

	////////////////////////////////////////////////////////////////////////////////
	// asynchronous inputs
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sleep_sync_q <= {2{ftbs_pkg::SLEEP_RST}};
			oe_sync_q    <= 2'h0;
		end else begin
			sleep_sync_q <= {sleep_sync_q[0], sleep_request_i};
			oe_sync_q    <= {oe_sync_q[0], ~output_enable_n_i};
		end
	end

	assign sleep     = sleep_sync_q[1];
	assign oe_active = oe_sync_q[1];
	assign low_power_sleep_state_o = sleep;

	////////////////////////////////////////////////////////////////////////////////
	// command decode
	assign run      = ~sleep & ~ctrl_i.clock_enable_n & buf_ready;
	assign selected = ~ctrl_i.chip_select_low_primary_n
		& ~ctrl_i.chip_select_low_secondary_n
		& ctrl_i.chip_select_high;
	assign load      = ~ctrl_i.burst_advance_load;
	assign advance   = ctrl_i.burst_advance_load;
	assign new_read  = load & selected & ctrl_i.read_write_n;
	assign new_write = load & selected & ~ctrl_i.read_write_n;
	assign cont_burst = advance & (op_q != ftbs_pkg::FTBS_IDLE);
	assign next_cnt  = burst_cnt_q + 2'h1;

	always_comb begin
		cur_addr = base_addr_q;
		if (load) begin
			cur_addr = addr_i;
		end else begin
			cur_addr[1:0] = burst_low(base_addr_q[1:0], next_cnt,
				burst_order_select_i);
		end
	end

	assign do_write = run & (new_write
		| (cont_burst & (op_q == ftbs_pkg::FTBS_WRITE)));
	assign do_read  = run & (new_read
		| (cont_burst & (op_q == ftbs_pkg::FTBS_READ)));

	////////////////////////////////////////////////////////////////////////////////
	// burst state
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			op_q <= ftbs_pkg::FTBS_IDLE;
		end else if (run) begin
			case ({load, selected})
				2'b11: begin
					op_q <= ctrl_i.read_write_n ? ftbs_pkg::FTBS_READ
						: ftbs_pkg::FTBS_WRITE;
				end
				2'b10: begin
					op_q <= ftbs_pkg::FTBS_IDLE;
				end
				default: begin
					op_q <= op_q;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			base_addr_q <= '0;
			burst_cnt_q <= ftbs_pkg::BURST_CNT_RST;
		end else if (run) begin
			if (new_read | new_write) begin
				base_addr_q <= addr_i;
				burst_cnt_q <= ftbs_pkg::BURST_CNT_RST;
			end else if (cont_burst) begin
				burst_cnt_q <= next_cnt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// byte-lane array
	assign lane_we = ~byte_write_group_n_i;

	generate
		for (genvar g = 0; g < LANES; g++) begin : g_lane
			assign lane_mask[g*LANE_W +: LANE_W] = {LANE_W{lane_we[g]}};
		end
	endgenerate

	// one writer for the whole array, lanes merged by mask
	always_ff @(posedge sys_clk_i) begin
		if (do_write) begin
			array_q[cur_addr] <= (array_q[cur_addr] & ~lane_mask) | (data_i & lane_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output data and drivers
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			drive_q <= 1'b0;
			dout_q  <= '0;
		end else if (sleep) begin
			drive_q <= 1'b0;
		end else if (run) begin
			drive_q <= do_read;
			if (do_read) begin
				dout_q <= array_q[cur_addr];
			end
		end
	end

	assign data_o    = dout_q;
	assign data_oe_o = {DW{drive_q & oe_active & ~sleep}};

	////////////////////////////////////////////////////////////////////////////////
	// read data stream
	assign buf_in_valid = drive_q & oe_active & ~sleep & ~ctrl_i.clock_enable_n;

	ftbs_skid #(
		.W(DW)
	) u_skid (
		.sys_clk_i   (sys_clk_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (buf_in_valid),
		.in_ready_o  (buf_ready),
		.in_data_i   (dout_q),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i),
		.out_data_o  (rd_data_o)
	);
endmodule : ftbs_ctrl

// ===== ftbs_ctrl_asserts.sv
/* port checker for ftbs_ctrl.
 * assumes the design's two-flop syncs on sleep and output enable. */
`timescale 1ns/1ps
module ftbs_ctrl_asserts #(
	parameter int LANES  = 4,
	parameter int LANE_W = 9
) (
	input wire logic                    sys_clk_i,
	input wire logic                    reset_n_i,
	input wire ftbs_pkg::ftbs_ctrl_t    ctrl_i,
	input wire logic                    output_enable_n_i,
	input wire logic                    sleep_request_i,
	input wire logic [LANES*LANE_W-1:0] data_o,
	input wire logic [LANES*LANE_W-1:0] data_oe_o,
	input wire logic                    low_power_sleep_state_o,
	input wire logic                    rd_valid_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	wire take = !ctrl_i.clock_enable_n && !ctrl_i.burst_advance_load
		&& !low_power_sleep_state_o && !rd_valid_o;
	wire sel = !ctrl_i.chip_select_low_primary_n && !ctrl_i.chip_select_low_secondary_n
		&& ctrl_i.chip_select_high;
	////////////////////////////////////////////////////////////////////////////////
	desel_quiet_a: assert property (take && !sel |=> data_oe_o == '0)
		else $error("drive after deselect");
	write_quiet_a: assert property (take && sel && !ctrl_i.read_write_n |=> data_oe_o == '0)
		else $error("drive after write");
	read_drive_a: assert property ((!sleep_request_i && !output_enable_n_i)[*3] ##0
		take && sel && ctrl_i.read_write_n |=> data_oe_o == '1) else $error("no drive on read");
	dummy_quiet_a: assert property (output_enable_n_i[*4] |=> data_oe_o == '0)
		else $error("drive while disabled");
	sleep_enter_a: assert property (sleep_request_i[*3] |=> low_power_sleep_state_o)
		else $error("sleep not entered");
	sleep_quiet_a: assert property (low_power_sleep_state_o |-> data_oe_o == '0)
		else $error("drive while asleep");
	powerup_quiet_a: assert property ($rose(reset_n_i) |-> data_oe_o == '0 ##1 data_oe_o == '0)
		else $error("drive at power-up");
	stall_hold_a: assert property ((!sleep_request_i)[*3] ##0 ctrl_i.clock_enable_n
		|=> $stable(data_o)) else $error("data moved in stall");
endmodule : ftbs_ctrl_asserts
bind ftbs_ctrl ftbs_ctrl_asserts #(.LANES(LANES), .LANE_W(LANE_W)) u_asserts (
	.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ctrl_i(ctrl_i),
	.output_enable_n_i(output_enable_n_i), .sleep_request_i(sleep_request_i),
	.data_o(data_o), .data_oe_o(data_oe_o),
	.low_power_sleep_state_o(low_power_sleep_state_o), .rd_valid_o(rd_valid_o));

// ===== ftbs_mc_model.sv
/* memory controller model driving the sram command bus.
 * assumes calls at the falling edge; returns one falling edge later. */
`timescale 1ns/1ps
module ftbs_mc_model (
	input  wire logic            sys_clk_i,
	output ftbs_pkg::ftbs_ctrl_t ctrl_o,
	output logic [16:0]          addr_o,
	output logic [3:0]           bw_n_o,
	output logic [35:0]          data_o
);
	initial begin
		ctrl_o = 6'h32;
		addr_o = '0;
		bw_n_o = 4'hF;
		data_o = '0;
	end
	task cyc(input logic s, v, r, k, input logic [3:0] b, input logic [16:0] a,
		input logic [35:0] d);
		ctrl_o = {~s, ~s, s, v, r, k}; // wait state by clock enable high
		addr_o = a;
		bw_n_o = b;
		data_o = d; // fresh random word from the bench each cycle, may repeat the last one
		@(negedge sys_clk_i);
	endtask : cyc
endmodule : ftbs_mc_model

// ===== tb_flow_through_burst_sram_control.sv
/* self-checking bench for ftbs_ctrl against an array and read-queue model.
 * assumes read stream always accepted; inputs move at falling edges. */
`timescale 1ns/1ps
module tb_flow_through_burst_sram_control;
	logic                 sys_clk_i = 1'b0;
	logic                 reset_n_i = 1'b0;
	logic                 oe_n = 1'b0, sleep = 1'b0, order = 1'b0, lp, slp = 1'b0, exp_oe;
	ftbs_pkg::ftbs_ctrl_t ctrl;
	logic [16:0]          addr, base;
	logic [3:0]           bw_n;
	logic [35:0]          wdata, rdata, oe, exp_d;
	logic [35:0]          mem [logic [16:0]];
	logic [35:0]          rq [$], rd_data;
	logic                 rd_valid;
	int                   n_errors = 0, checks = 0, ticks = 0, op, n, k;
	initial forever #4 sys_clk_i = ~sys_clk_i;
	ftbs_mc_model mc (.sys_clk_i(sys_clk_i), .ctrl_o(ctrl), .addr_o(addr), .bw_n_o(bw_n),
		.data_o(wdata));
	ftbs_ctrl uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ctrl_i(ctrl), .addr_i(addr),
		.byte_write_group_n_i(bw_n), .output_enable_n_i(oe_n), .sleep_request_i(sleep),
		.burst_order_select_i(order), .data_i(wdata), .data_o(rdata), .data_oe_o(oe),
		.low_power_sleep_state_o(lp), .rd_valid_o(rd_valid), .rd_ready_i(1'b1),
		.rd_data_o(rd_data));
	////////////////////////////////////////////////////////////////////////////////
	task cmp_word(input string what, input logic [35:0] e, g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_word
	task cyc(input logic s, v, r, k_n, input logic [3:0] b, input logic [16:0] a);
		logic [35:0] d;
		logic [16:0] cur;
		d = 36'({$urandom, $urandom});
		if (!k_n && !slp) begin
			if (!v) begin
				op = !s ? 0 : r ? 1 : 2;
				base = a;
				n = 0;
			end else if (op != 0)
				n = (n + 1) % 4;
			cur = base;
			cur[1:0] = order ? base[1:0] ^ 2'(n) : base[1:0] + 2'(n);
			exp_d = mem.exists(cur) ? mem[cur] : '0;
			for (int i = 0; i < 4; i++)
				if (op == 2 && !b[i]) exp_d[i*9+:9] = d[i*9+:9];
			if (op == 2) mem[cur] = exp_d;
			exp_oe = op == 1 && !oe_n;
			if (exp_oe) rq.push_back(exp_d);
		end
		mc.cyc(s, v, r, k_n, b, a, d);
		cmp_word("drive", {36{exp_oe && !slp}}, oe);
		if (exp_oe && !slp) cmp_word("read data", exp_d, rdata);
	endtask : cyc
	task report_and_stop;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	always @(posedge sys_clk_i) begin
		ticks++;
		if (ticks == 3000) begin
			n_errors++;
			report_and_stop();
		end
	end
	always @(negedge sys_clk_i)
		if (rd_valid) cmp_word("stream data", rq.size() != 0 ? rq.pop_front() : 'x, rd_data);
	initial begin
		void'($urandom(32'h1D1E9C42));
		for (int o = 0; o < 2; o++) begin
			reset_n_i = 1'b0;
			order = o[0]; // held for the whole pass; second pass flips it
			op = 0;
			exp_oe = 1'b0;
			mem.delete();
			rq.delete();
			repeat (16) @(negedge sys_clk_i);
			cmp_word("drive", '0, oe);
			reset_n_i = 1'b1;
			repeat (3) cyc(0, 0, 1, 0, 4'hF, 0);
			for (k = 0; k < 8; k++) cyc(1, k % 4 != 0, 0, 0, 4'h0, 17'(k));
			for (k = 0; k < 150; k++) cyc($urandom % 5 != 0, $urandom % 3 == 0, 1'($urandom),
				$urandom % 4 == 0, 4'($urandom), 17'($urandom % 8));
			cyc(1, 0, 1, 0, 4'hF, 5);
			for (k = 0; k < 5; k++) cyc(0, 1, 0, k == 2, 4'h0, 0);
			oe_n = 1'b1;
			repeat (3) cyc(0, 0, 1, 0, 4'hF, 0);
			cyc(1, 0, 1, 0, 4'hF, 3);
			oe_n = 1'b0;
			sleep = 1'b1;
			repeat (3) cyc(0, 0, 1, 0, 4'hF, 0);
			slp = 1'b1;
			cyc(1, 0, 0, 0, 4'h0, 1);
			cmp_word("sleep", 36'(1), 36'(lp));
			slp = 1'b0;
			sleep = 1'b0;
			repeat (3) cyc(0, 0, 1, 0, 4'hF, 0);
			cyc(1, 0, 1, 0, 4'hF, 1);
			repeat (2) cyc(0, 0, 1, 0, 4'hF, 0);
			cmp_word("stream backlog", '0, 36'(rq.size()));
			$display("test order %0d done", o);
		end
		report_and_stop();
	end
endmodule : tb_flow_through_burst_sram_control
